// ---- rtl/frp_params.svh ----
`ifndef FRP_PARAMS_SVH
`define FRP_PARAMS_SVH

// ==========================================================
// read parameter register layout
`define FRP_RESET_VALUE     8'h00
`define FRP_PIN_SEL_BIT     7
`define FRP_WAIT_MSB        6
`define FRP_WAIT_LSB        3
`define FRP_WRAP_EN_BIT     2
`define FRP_BURST_MSB       1
`define FRP_BURST_LSB       0

// ==========================================================
// set command opcodes
`define FRP_OPC_SET_NV      8'h65
`define FRP_OPC_SET_VOL_A   8'hc0
`define FRP_OPC_SET_VOL_B   8'h63

// ==========================================================
// default wait counts when the field is zero
`define FRP_WAIT_DEF_LONG   4'h8
`define FRP_WAIT_DEF_MID    4'h6
`define FRP_WAIT_DEF_SHORT  4'h4

// ==========================================================
// wrap burst lengths in bytes, whole array coded as zero
`define FRP_WRAP_8          7'h08
`define FRP_WRAP_16         7'h10
`define FRP_WRAP_32         7'h20
`define FRP_WRAP_64         7'h40
`define FRP_WRAP_ARRAY      7'h00

// ==========================================================
// serial framing
`define FRP_BYTE_BITS       5'h08

`endif

// ---- rtl/frp_pkg.sv ----
package frp_pkg;

  // ==========================================================
  // read command classes, used for default wait counts
  typedef enum logic [2:0]
  {
    FRP_RK_FAST_SINGLE,
    FRP_RK_FAST_FOUR,
    FRP_RK_DUAL_OUT,
    FRP_RK_DUAL_IO,
    FRP_RK_QUAD_OUT,
    FRP_RK_QUAD_IO
  } frp_rkind_t;

  // ==========================================================
  // serial command decoder states
  typedef enum logic [1:0]
  {
    FRP_CMD_OPCODE,
    FRP_CMD_DATA,
    FRP_CMD_IGNORE
  } frp_cmd_t;

  // ==========================================================
  // power-up load states
  typedef enum logic
  {
    FRP_PU_LOAD,
    FRP_PU_RUN
  } frp_pu_t;

endpackage

// ---- rtl/frp_read_param.sv ----
// Behaviour
// R1 - keep a non-volatile copy and a volatile working copy of the parameters
// R2 - on power-up the volatile copy is loaded from the non-volatile copy
// R3 - single line, no quad, relocated reset: bit 7 picks pause (0) or reset (1)
// R4 - with dedicated reset pin in use the shared pin is always pause; the code makes it data line 3 instead under quad enable or four-line mode
// R5 - quad enable or four-line mode ignores pin select; pin is data line 3
// R6 - wait field 1..15 gives that many wait cycles
// R7 - wait field 0 gives command default: 8, 6 or 4
// R8 - wrap disabled wraps at array end; enabled wraps within burst length
// R9 - burst code 00/01/10/11 gives 8/16/32/64 bytes
// R10 - a set command writes all eight bits at once
// R11 - opcode 65h writes the non-volatile copy
// R12 - opcode c0h or 63h writes only the volatile copy
// R13 - host picks a wait count that suits its clock rate
// R14 - both copies start as all zero
// R15 - host never issues double rate dual io read in four-line mode
// R16 - quad enable turns write-protect and pause/reset pins into data lines
// R17 - relocate bit disables dedicated reset and moves it to the shared pin
// R18 - new volatile value governs from the next read command on
`timescale 1ns/1ps
`include "frp_params.svh"

module frp_read_param
  import frp_pkg::*;
#(
  parameter bit HAS_DED_RESET = 1'b1
) (
  input  wire logic       MCLK_I,           // block clock, 125 MHz
  input  wire logic       RESETN_I,         // async reset, active low
  input  wire logic       CE_N_I,           // serial chip enable pin, active low
  input  wire logic       SCK_I,            // serial clock pin
  input  wire logic [3:0] IO_I,             // serial data pins, io0 in single line
  input  wire logic       PWR_CYCLE_I,      // high while supply is cycled
  input  wire logic       QUAD_EN_I,        // quad enable bit from status logic
  input  wire logic       FOUR_LINE_MODE_I, // four-line command mode active
  input  wire logic       RELOCATE_I,       // reset pin relocate bit
  input  wire logic       READ_START_I,     // pulse: read command begins
  input  wire frp_rkind_t READ_KIND_I,      // class of that read command
  output logic      [7:0] VOL_PARAM_O,      // volatile working copy
  output logic      [7:0] NV_PARAM_O,       // non-volatile copy
  output logic      [3:0] WAIT_CYCLES_O,    // wait cycles of current read
  output logic            WRAP_EN_O,        // current read wraps in burst
  output logic      [6:0] WRAP_BYTES_O,     // burst length, zero = whole array
  output logic            PIN_PAUSE_O,      // shared pin acts as pause
  output logic            PIN_RESET_O,      // shared pin acts as reset
  output logic            PIN_DATA3_O,      // shared pin is data line 3
  output logic            WP_DATA2_O,       // write-protect pin is data line 2
  output logic            DED_RESET_EN_O,   // dedicated reset pin active
  output logic            LOAD_BUSY_O       // power-up load in progress
);

  // ==========================================================
  // helpers
  function automatic logic [3:0] wait_count(input logic [7:0] p, input frp_rkind_t k);
    logic [3:0] field;
    field = p[`FRP_WAIT_MSB:`FRP_WAIT_LSB];
    // R6 nonzero field
    if (field != 4'h0)
      return field;
    // R7 command defaults
    case (k)
      FRP_RK_FAST_FOUR,
      FRP_RK_QUAD_IO:    return `FRP_WAIT_DEF_MID;
      FRP_RK_DUAL_IO:    return `FRP_WAIT_DEF_SHORT;
      default:           return `FRP_WAIT_DEF_LONG;
    endcase
  endfunction

  function automatic logic [6:0] wrap_bytes(input logic [7:0] p);
    // R8 wrap disabled
    if (!p[`FRP_WRAP_EN_BIT])
      return `FRP_WRAP_ARRAY;
    // R9 burst code
    case (p[`FRP_BURST_MSB:`FRP_BURST_LSB])
      2'h0:    return `FRP_WRAP_8;
      2'h1:    return `FRP_WRAP_16;
      2'h2:    return `FRP_WRAP_32;
      default: return `FRP_WRAP_64;
    endcase
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [6:0] pins_sync;
  logic       ce_n;
  logic       sck;
  logic [3:0] io;
  logic       pwr;

  frp_sync #(
    .WIDTH (7)
  ) u_sync (
    .clk_i   (MCLK_I),
    .rst_n_i (RESETN_I),
    .d_i     ({PWR_CYCLE_I, IO_I, SCK_I, CE_N_I}),
    .q_o     (pins_sync)
  );

  assign ce_n = pins_sync[0];
  assign sck  = pins_sync[1];
  assign io   = pins_sync[5:2];
  assign pwr  = pins_sync[6];

  // ==========================================================
  // state
  frp_pu_t    pu;
  frp_pu_t    next_pu;
  frp_cmd_t   cmd;
  frp_cmd_t   next_cmd;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [7:0] sr;
  logic [7:0] next_sr;
  logic [7:0] opc;
  logic [7:0] next_opc;
  logic [7:0] vol;
  logic [7:0] next_vol;
  logic [7:0] nv;
  logic [7:0] next_nv;
  logic [7:0] act;
  logic [7:0] next_act;
  logic       sck_d;
  logic       pwr_d;
  logic       ce_n_d;
  logic       pin_pause;
  logic       next_pin_pause;
  logic       pin_reset;
  logic       next_pin_reset;
  logic       pin_data3;
  logic       next_pin_data3;
  logic       ded_reset;
  logic       next_ded_reset;
  logic [3:0] wcnt;
  logic [3:0] next_wcnt;

  logic       sck_rise;
  logic       frame_end;
  logic [4:0] step;
  logic [7:0] shifted;

  // sck edges are found by sampling; sck must stay well below mclk / 4
  assign sck_rise  = sck & ~sck_d & ~ce_n;
  assign frame_end = ce_n & ~ce_n_d;
  assign step      = FOUR_LINE_MODE_I ? 5'h04 : 5'h01;
  assign shifted   = FOUR_LINE_MODE_I ? {sr[3:0], io} : {sr[6:0], io[0]};

  // ==========================================================
  // next state
  always_comb
  begin
    next_pu        = pu;
    next_cmd       = cmd;
    next_cnt       = cnt;
    next_sr        = sr;
    next_opc       = opc;
    next_vol       = vol;
    next_nv        = nv;
    next_act       = act;
    next_wcnt      = wcnt;

    // R2 power-up load
    case (pu)
      FRP_PU_LOAD:
      begin
        next_vol = nv;
        if (!pwr)
          next_pu = FRP_PU_RUN;
      end
      default:
      begin
        if (pwr && !pwr_d)
          next_pu = FRP_PU_LOAD;
      end
    endcase

    if (ce_n)
    begin
      // a set command counts only when exactly one data byte was sent
      if (frame_end && cmd == FRP_CMD_DATA && cnt == `FRP_BYTE_BITS && pu == FRP_PU_RUN)
      begin
        // R10 R11 whole byte into non-volatile copy
        if (opc == `FRP_OPC_SET_NV)
          next_nv = sr;
        // R12 either volatile opcode
        else
          next_vol = sr;
      end
      next_cmd = FRP_CMD_OPCODE;
      next_cnt = 5'h00;
    end
    else if (sck_rise)
    begin
      case (cmd)
        FRP_CMD_OPCODE:
        begin
          next_sr  = shifted;
          next_cnt = 5'(cnt + step);
          if (next_cnt == `FRP_BYTE_BITS)
          begin
            next_opc = shifted;
            next_cnt = 5'h00;
            if (shifted == `FRP_OPC_SET_NV || shifted == `FRP_OPC_SET_VOL_A ||
                shifted == `FRP_OPC_SET_VOL_B)
              next_cmd = FRP_CMD_DATA;
            else
              next_cmd = FRP_CMD_IGNORE;
          end
        end
        FRP_CMD_DATA:
        begin
          if (cnt == `FRP_BYTE_BITS)
            next_cmd = FRP_CMD_IGNORE;
          else
          begin
            next_sr  = shifted;
            next_cnt = 5'(cnt + step);
          end
        end
        default: next_cnt = cnt;
      endcase
    end

    // R18 snapshot at read start
    if (READ_START_I)
    begin
      next_act  = {vol[`FRP_WRAP_EN_BIT], wrap_bytes(vol)};
      next_wcnt = wait_count(vol, READ_KIND_I);
    end

    // R5 R16 quad or four-line takes the pins as data lines
    next_pin_data3 = QUAD_EN_I | FOUR_LINE_MODE_I;
    // R17 relocation disables the dedicated reset pin
    next_ded_reset = HAS_DED_RESET & ~RELOCATE_I;
    // R3 R4 pin select only when the dedicated reset is moved off
    next_pin_reset = ~next_pin_data3 & vol[`FRP_PIN_SEL_BIT] & RELOCATE_I;
    next_pin_pause = ~next_pin_data3 & ~next_pin_reset;
  end

  // ==========================================================
  // registers
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      pu        <= FRP_PU_LOAD;
      cmd       <= FRP_CMD_OPCODE;
      cnt       <= 5'h00;
      sr        <= 8'h00;
      opc       <= 8'h00;
      // R1 R14 both copies leave the factory as zero
      vol       <= `FRP_RESET_VALUE;
      nv        <= `FRP_RESET_VALUE;
      act       <= `FRP_RESET_VALUE;
      wcnt      <= `FRP_WAIT_DEF_LONG;
      sck_d     <= 1'b0;
      pwr_d     <= 1'b0;
      ce_n_d    <= 1'b1;
      pin_pause <= 1'b1;
      pin_reset <= 1'b0;
      pin_data3 <= 1'b0;
      ded_reset <= 1'b0;
    end
    else
    begin
      pu        <= next_pu;
      cmd       <= next_cmd;
      cnt       <= next_cnt;
      sr        <= next_sr;
      opc       <= next_opc;
      vol       <= next_vol;
      nv        <= next_nv;
      act       <= next_act;
      wcnt      <= next_wcnt;
      sck_d     <= sck;
      pwr_d     <= pwr;
      ce_n_d    <= ce_n;
      pin_pause <= next_pin_pause;
      pin_reset <= next_pin_reset;
      pin_data3 <= next_pin_data3;
      ded_reset <= next_ded_reset;
    end
  end

  // ==========================================================
  // outputs
  assign VOL_PARAM_O    = vol;
  assign NV_PARAM_O     = nv;
  assign WAIT_CYCLES_O  = wcnt;
  assign WRAP_EN_O      = act[7];
  assign WRAP_BYTES_O   = act[6:0];
  assign PIN_PAUSE_O    = pin_pause;
  assign PIN_RESET_O    = pin_reset;
  assign PIN_DATA3_O    = pin_data3;
  assign WP_DATA2_O     = pin_data3;
  assign DED_RESET_EN_O = ded_reset;
  assign LOAD_BUSY_O    = (pu == FRP_PU_LOAD);

endmodule

// ---- rtl/frp_sync.sv ----
`timescale 1ns/1ps

// ==========================================================
// two flop synchroniser; first stage feeds only the second
module frp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,   // sampling clock
  input  wire logic             rst_n_i, // async reset, active low
  input  wire logic [WIDTH-1:0] d_i,     // asynchronous input
  output logic      [WIDTH-1:0] q_o      // synchronised output
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stage1 <= '0;
      q_o    <= '0;
    end
    else
    begin
      stage1 <= d_i;
      q_o    <= stage1;
    end
  end

endmodule

// ---- testbench/flash_read_parameter_register_bench.sv ----
`timescale 1ns/1ps
module flash_read_parameter_register_bench;
  import frp_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, pwr = 1'b0, quad = 1'b0, four = 1'b0, reloc = 1'b0, rs = 1'b0;
  frp_rkind_t kind = FRP_RK_FAST_SINGLE;
  logic ce_n, sck, wen, pp, pr, pd, wd, dr, busy;
  logic [3:0] io, wt;
  logic [7:0] vol, nv;
  logic [6:0] wb;
  logic [3:0] dflt [6] = '{4'h8, 4'h6, 4'h8, 4'h4, 4'h8, 4'h6};
  int err_count = 0;
  int comparisons = 0;
  always #4 mclk = ~mclk;
  frp_host HOST (.ce_n_o(ce_n), .sck_o(sck), .io_o(io));
  frp_read_param DUT (
    .MCLK_I(mclk), .RESETN_I(rst_n), .CE_N_I(ce_n), .SCK_I(sck), .IO_I(io),
    .PWR_CYCLE_I(pwr), .QUAD_EN_I(quad), .FOUR_LINE_MODE_I(four), .RELOCATE_I(reloc),
    .READ_START_I(rs), .READ_KIND_I(kind), .VOL_PARAM_O(vol), .NV_PARAM_O(nv),
    .WAIT_CYCLES_O(wt), .WRAP_EN_O(wen), .WRAP_BYTES_O(wb), .PIN_PAUSE_O(pp),
    .PIN_RESET_O(pr), .PIN_DATA3_O(pd), .WP_DATA2_O(wd), .DED_RESET_EN_O(dr),
    .LOAD_BUSY_O(busy)
  );
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // commit lands a few cycles after the frame ends
  task automatic wr(input logic [7:0] opc, input logic [7:0] d, input bit f, input int nd);
    HOST.send(opc, d, f, nd);
    repeat (8) @(negedge mclk);
  endtask
  task automatic rd(input frp_rkind_t k, input logic [3:0] w, input logic [6:0] b);
    @(negedge mclk);
    kind = k;
    rs = 1'b1;
    @(negedge mclk);
    rs = 1'b0;
    check({4'h0, wt}, {4'h0, w});
    check({wen, wb}, {b != 7'h00, b});
  endtask
  task automatic mode(input logic q, input logic f, input logic r, input logic [4:0] e);
    @(negedge mclk);
    quad = q;
    four = f;
    reloc = r;
    repeat (2) @(negedge mclk);
    check({3'h0, pp, pr, pd, wd, dr}, {3'h0, e});
  endtask
  initial
  begin
    #100000;
    err_count++;
    end_of_test();
  end
  initial
  begin
    logic [7:0] d;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    check(vol, 8'h00);
    check(nv, 8'h00);
    mode(1'b0, 1'b0, 1'b0, 5'b10001);
    for (int i = 0; i < 6; i++)
      rd(frp_rkind_t'(i), dflt[i], 7'h00);
    for (int b = 0; b < 4; b++)
    begin
      d = {1'b0, 4'(b * 5 + (b == 0)), 1'b1, 2'(b)};
      wr(b[0] ? 8'h63 : 8'hc0, d, 1'b0, 8);
      check(vol, d);
      check(nv, 8'h00);
      rd(FRP_RK_QUAD_IO, d[6:3], 7'h08 << b);
    end
    wr(8'hc0, 8'h10, 1'b0, 8);
    check({4'h0, wt}, 8'h0f);
    rd(FRP_RK_DUAL_IO, 4'h2, 7'h00);
    wr(8'h66, 8'h11, 1'b0, 8);
    check(vol, 8'h10);
    wr(8'hc0, 8'h11, 1'b0, 7);
    check(vol, 8'h10);
    wr(8'h65, 8'h5a, 1'b0, 8);
    check(nv, 8'h5a);
    check(vol, 8'h10);
    pwr = 1'b1;
    repeat (6) @(negedge mclk);
    check({7'h00, busy}, 8'h01);
    pwr = 1'b0;
    repeat (6) @(negedge mclk);
    check({7'h00, busy}, 8'h00);
    check(vol, 8'h5a);
    wr(8'h63, 8'h80, 1'b0, 8);
    mode(1'b0, 1'b0, 1'b1, 5'b01000);
    mode(1'b0, 1'b0, 1'b0, 5'b10001);
    mode(1'b1, 1'b0, 1'b1, 5'b00110);
    mode(1'b0, 1'b1, 1'b0, 5'b00111);
    wr(8'hc0, 8'h00, 1'b1, 8);
    check(vol, 8'h00);
    mode(1'b0, 1'b0, 1'b0, 5'b10001);
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    check(nv, 8'h00);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    check(vol, 8'h00);
    check({3'h0, pp, pr, pd, wd, dr}, 8'h11);
    wr(8'h63, 8'h3c, 1'b0, 8);
    check(vol, 8'h3c);
    check(nv, 8'h00);
    end_of_test();
  end
endmodule

// ---- testbench/frp_host.sv ----
`timescale 1ns/1ps
module frp_host (
  output logic       ce_n_o, // chip enable, active low
  output logic       sck_o,  // still between frames
  output logic [3:0] io_o    // data lines
);
  initial
  begin
    ce_n_o = 1'b1;
    sck_o = 1'b0;
    io_o = 4'h5;
  end
  // only opcode plus data frames of any opcode, sck kept at 64 ns
  task automatic send(input logic [7:0] opc, input logic [7:0] dat, input bit four, input int nd);
    logic [15:0] sh;
    int n;
    sh = {opc, dat};
    n = four ? (8 + nd) / 4 : 8 + nd;
    ce_n_o = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      io_o = four ? sh[15:12] : {~sh[15], ~sh[15], ~sh[15], sh[15]};
      sh = four ? sh << 4 : sh << 1;
      #32 sck_o = 1'b1;
      #32 sck_o = 1'b0;
    end
    #32 ce_n_o = 1'b1;
    // released lines must not keep the last bit
    io_o = ~io_o;
    #64;
  endtask
endmodule

// ---- testbench/frp_read_param_properties.sv ----
`timescale 1ns/1ps
module frp_read_param_properties
  import frp_pkg::*;
#(
  parameter bit HAS_DED_RESET = 1'b1
) (
  input wire logic       MCLK_I,           // clock
  input wire logic       RESETN_I,         // reset
  input wire logic       CE_N_I,           // enable
  input wire logic       SCK_I,            // sck
  input wire logic [3:0] IO_I,             // data
  input wire logic       PWR_CYCLE_I,      // supply
  input wire logic       QUAD_EN_I,        // quad
  input wire logic       FOUR_LINE_MODE_I, // four-line
  input wire logic       RELOCATE_I,       // relocate
  input wire logic       READ_START_I,     // read start
  input wire frp_rkind_t READ_KIND_I,      // read kind
  input wire logic [7:0] VOL_PARAM_O,      // volatile
  input wire logic [7:0] NV_PARAM_O,       // persistent
  input wire logic [3:0] WAIT_CYCLES_O,    // waits
  input wire logic       WRAP_EN_O,        // wrap
  input wire logic [6:0] WRAP_BYTES_O,     // burst
  input wire logic       PIN_PAUSE_O,      // pause
  input wire logic       PIN_RESET_O,      // reset pin
  input wire logic       PIN_DATA3_O,      // data 3
  input wire logic       WP_DATA2_O,       // data 2
  input wire logic       DED_RESET_EN_O,   // dedicated
  input wire logic       LOAD_BUSY_O       // loading
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESETN_I);
  // ==========================================================
  // assertions
  factory_zero_a: assert property ($rose(RESETN_I) |-> VOL_PARAM_O == 8'h00 && NV_PARAM_O == 8'h00)
    else $error("copies not zero after reset");
  wait_max_a: assert property (READ_START_I && VOL_PARAM_O[6:3] == 4'hf |=> WAIT_CYCLES_O == 4'hf)
    else $error("wait count 15 wrong");
  wait_one_a: assert property (READ_START_I && VOL_PARAM_O[6:3] == 4'h1 |=> WAIT_CYCLES_O == 4'h1)
    else $error("wait count 1 wrong");
  wait_dual_a: assert property (READ_START_I && VOL_PARAM_O[6:3] == 4'h0 &&
    READ_KIND_I == FRP_RK_DUAL_IO |=> WAIT_CYCLES_O == 4'h4) else $error("dual io default wrong");
  wrap_off_a: assert property (READ_START_I && !VOL_PARAM_O[2] |=> !WRAP_EN_O && WRAP_BYTES_O == 7'h00)
    else $error("wrap not whole array");
  wrap_len_a: assert property (READ_START_I && VOL_PARAM_O[2:0] == 3'h7 |=> WRAP_EN_O && WRAP_BYTES_O == 7'h40)
    else $error("burst 64 wrong");
  data_line_a: assert property (QUAD_EN_I || FOUR_LINE_MODE_I |=> PIN_DATA3_O && WP_DATA2_O &&
    !PIN_PAUSE_O && !PIN_RESET_O) else $error("pin not data line");
  ded_reset_a: assert property (RELOCATE_I |=> !DED_RESET_EN_O)
    else $error("dedicated reset still on");
  pause_keep_a: assert property (!RELOCATE_I && !QUAD_EN_I && !FOUR_LINE_MODE_I |=> PIN_PAUSE_O && !PIN_RESET_O)
    else $error("shared pin not pause");
  load_busy_a: assert property ($rose(PWR_CYCLE_I) |-> ##[1:4] LOAD_BUSY_O)
    else $error("no load after power cycle");
  load_copy_a: assert property ($fell(LOAD_BUSY_O) |-> VOL_PARAM_O == NV_PARAM_O)
    else $error("volatile not loaded");
  cover property (READ_START_I && VOL_PARAM_O[2]);
  cover property ($fell(LOAD_BUSY_O) && NV_PARAM_O != 8'h00);
  cover property (PIN_RESET_O);
endmodule

bind frp_read_param frp_read_param_properties #(.HAS_DED_RESET(HAS_DED_RESET)) u_props (
  .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .CE_N_I(CE_N_I), .SCK_I(SCK_I), .IO_I(IO_I),
  .PWR_CYCLE_I(PWR_CYCLE_I), .QUAD_EN_I(QUAD_EN_I), .FOUR_LINE_MODE_I(FOUR_LINE_MODE_I),
  .RELOCATE_I(RELOCATE_I), .READ_START_I(READ_START_I), .READ_KIND_I(READ_KIND_I),
  .VOL_PARAM_O(VOL_PARAM_O), .NV_PARAM_O(NV_PARAM_O), .WAIT_CYCLES_O(WAIT_CYCLES_O),
  .WRAP_EN_O(WRAP_EN_O), .WRAP_BYTES_O(WRAP_BYTES_O), .PIN_PAUSE_O(PIN_PAUSE_O),
  .PIN_RESET_O(PIN_RESET_O), .PIN_DATA3_O(PIN_DATA3_O), .WP_DATA2_O(WP_DATA2_O),
  .DED_RESET_EN_O(DED_RESET_EN_O), .LOAD_BUSY_O(LOAD_BUSY_O)
);
